// >>> tpl_map.svh
/*
 * Constants for the tape-to-printer off-line link controller.
 * Assumes mclk at 125 MHz; included by bare name.
 */
`ifndef TPL_MAP_SVH
`define TPL_MAP_SVH
`define TPL_WORD_W        30
`define TPL_CHAR_W        6
`define TPL_CHARS_WORD    5
`define TPL_LINE_CHARS    120
`define TPL_MIN_WORDS     24
`define TPL_SPACE_CODE    6'h05
`define TPL_LETTER_LO     6'h06
`define TPL_LETTER_HI     6'h1F
`define TPL_DIGIT_LO      6'h30
`define TPL_DIGIT_HI      6'h39
`define TPL_CLK_MHZ       125
`define TPL_WORD_US       54
`define TPL_WORD_CYC      (`TPL_WORD_US * `TPL_CLK_MHZ)
`endif

// >>> tpl_pkg.sv
/*
 * Types for the tape-to-printer off-line link controller.
 * Assumes tpl_map.svh is compiled alongside.
 */
package tpl_pkg;
  typedef enum logic [2:0] {
    TPL_IDLE  = 3'b000,
    TPL_REQ   = 3'b001,
    TPL_STORE = 3'b010,
    TPL_PACE  = 3'b011,
    TPL_PRINT = 3'b100,
    TPL_STOP  = 3'b101
  } tpl_state_t;
  typedef enum logic [1:0] {
    TPL_PAPER_NONE = 2'b00,
    TPL_PAPER_LINE = 2'b01,
    TPL_PAPER_TOF  = 2'b10
  } tpl_paper_t;
endpackage : tpl_pkg

// >>> tpl_sync.sv
/*
 * Three-flop pin synchroniser; output changes once flops two and three agree.
 * Assumes an asynchronous input and the mclk domain.
 */
`timescale 1ns/1ps
module tpl_sync (
  input  wire logic mclk,   // clock
  input  wire logic rst_n,  // async reset
  input  wire logic din,    // raw pin
  output logic      dout    // filtered level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule : tpl_sync

// >>> tpl_ctrl.sv
/*
 * Printer-side controller of the off-line tape link: raises the word
 * demand, takes 30-bit words, unpacks characters into a line memory,
 * starts printing at 120 characters and steers paper on tape events.
 * Assumes the tape unit keeps its own side of the handshake and holds
 * data stable while its request is high.
 */
`timescale 1ns/1ps
`include "tpl_map.svh"
// Behaviour
// - words move by request and acknowledge only
// - our word demand is tape acknowledge
// - tape request is our acknowledge input
// - tape interrupt feeds external function; data direct
// - start only when tape side ready
// - entering off-line raises word demand
// - on acknowledge sample data, drop demand
// - repeat per word; print line, advance, restart
// - word splits into five characters, stored
// - accept one word every 54 microseconds
// - character count 120 starts print cycle
// - record under 24 words stops printing
// - five-space record stops without printing
// - end of record spaces, tape mark tops form
// - tape mark puts paper at top of form
// - characters use six-bit printer code
module tpl_ctrl (
  input  wire logic        mclk,          // clock, 125 MHz
  input  wire logic        rst_n,         // async reset, active low
  input  wire logic        offline,       // printer placed off-line
  input  wire logic        tape_ready,    // tape in printer mode, at load point
  input  wire logic        tape_req,      // tape input data request pin
  input  wire logic        tape_intr,     // tape interrupt pin
  input  wire logic        tape_mark,     // interrupt kind: 1 mark, 0 end of record
  input  wire logic [29:0] tape_data,     // parallel data pins
  input  wire logic        print_done,    // mechanism finished line
  input  wire logic [6:0]  rd_addr,       // line memory read address
  output logic             out_req,       // output data request pin
  output logic             print_start,   // pulse: print the stored line
  output logic             paper_line,    // pulse: advance one line
  output logic             paper_tof,     // pulse: top of form
  output logic             stopped,       // print operation stopped
  output logic             busy,          // transfer in progress
  output logic [5:0]       rd_char,       // line memory read data
  output logic             char_bad       // a received code is not printable
);
  localparam int WORD_CYC = `TPL_WORD_CYC;
  localparam int LINE_WORDS = `TPL_LINE_CHARS / `TPL_CHARS_WORD;

  tpl_pkg::tpl_state_t st_r;
  logic [5:0]  line_mem [0:`TPL_LINE_CHARS-1];
  logic [6:0]  char_cnt_r;
  logic [4:0]  word_cnt_r;
  logic [29:0] word_r;
  logic [2:0]  unpack_r;
  logic [12:0] pace_r;
  logic        all_space_r;
  logic        req_s;
  logic        ready_s;
  logic        intr_s;
  logic        intr_d_r;
  logic        mark_s;
  logic        intr_rise;

  // printable: letters, digits or space in six-bit printer code
  function automatic logic tpl_printable(input logic [5:0] c);
    tpl_printable = (c == `TPL_SPACE_CODE) ||
                    (c >= `TPL_LETTER_LO && c <= `TPL_LETTER_HI) ||
                    (c >= `TPL_DIGIT_LO && c <= `TPL_DIGIT_HI);
  endfunction : tpl_printable

  function automatic logic [5:0] tpl_char_of(input logic [29:0] w,
                                             input logic [2:0] i);
    // first character sits in the top six bits
    tpl_char_of = w[6'(29 - 6 * i) -: 6];
  endfunction : tpl_char_of

  tpl_sync u_req (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   (tape_req),
    .dout  (req_s)
  );
  tpl_sync u_intr (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   (tape_intr),
    .dout  (intr_s)
  );
  tpl_sync u_mark (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   (tape_mark),
    .dout  (mark_s)
  );
  // ready comes from the tape cabinet, so it is filtered like the others
  tpl_sync u_ready (
    .mclk  (mclk),
    .rst_n (rst_n),
    .din   (tape_ready),
    .dout  (ready_s)
  );

  assign intr_rise = intr_s & ~intr_d_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      intr_d_r <= 1'b0;
    end else begin
      intr_d_r <= intr_s;
    end
  end

  // handshake and sequencing
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= tpl_pkg::TPL_IDLE;
      out_req <= 1'b0;
      word_r  <= 30'h0;
      pace_r  <= 13'h0;
      busy    <= 1'b0;
    end else begin
      unique case (st_r)
        tpl_pkg::TPL_IDLE: begin
          out_req <= 1'b0;
          busy    <= 1'b0;
          if (offline && ready_s && !stopped) begin
            out_req <= 1'b1;
            busy    <= 1'b1;
            st_r    <= tpl_pkg::TPL_REQ;
          end
        end
        tpl_pkg::TPL_REQ: begin
          if (!offline) begin
            out_req <= 1'b0;
            st_r    <= tpl_pkg::TPL_IDLE;
          end else if (req_s) begin
            // data held stable while tape request stands
            word_r  <= tape_data;
            out_req <= 1'b0;
            st_r    <= tpl_pkg::TPL_STORE;
          end
        end
        tpl_pkg::TPL_STORE: begin
          if (unpack_r == 3'(`TPL_CHARS_WORD - 1)) begin
            pace_r <= 13'(WORD_CYC - `TPL_CHARS_WORD);
            st_r   <= tpl_pkg::TPL_PACE;
          end
        end
        tpl_pkg::TPL_PACE: begin
          // wait for tape to drop its request before next demand
          if (pace_r != 13'h0) begin
            pace_r <= pace_r - 13'h1;
          end else if (!req_s) begin
            if (char_cnt_r == 7'(`TPL_LINE_CHARS)) begin
              st_r <= tpl_pkg::TPL_PRINT;
            end else begin
              out_req <= offline;
              st_r    <= offline ? tpl_pkg::TPL_REQ : tpl_pkg::TPL_IDLE;
            end
          end
        end
        tpl_pkg::TPL_PRINT: begin
          if (print_done) begin
            st_r <= tpl_pkg::TPL_IDLE;
          end
        end
        tpl_pkg::TPL_STOP: begin
          busy <= 1'b0;
          if (!offline) begin
            st_r <= tpl_pkg::TPL_IDLE;
          end
        end
        default: st_r <= tpl_pkg::TPL_IDLE;
      endcase
      // short record seen at end-of-record ends the run
      if (intr_rise && !mark_s && st_r != tpl_pkg::TPL_PRINT &&
          (word_cnt_r < 5'(`TPL_MIN_WORDS) ||
           (word_cnt_r == 5'h1 && all_space_r))) begin
        out_req <= 1'b0;
        st_r    <= tpl_pkg::TPL_STOP;
      end
      // end of file: no new demand until the printer leaves off-line,
      // otherwise a fresh demand would skip the word pace
      if (intr_rise && mark_s) begin
        out_req <= 1'b0;
        st_r    <= tpl_pkg::TPL_STOP;
      end
    end
  end

  // character unpacking into the line memory
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      unpack_r    <= 3'h0;
      char_cnt_r  <= 7'h0;
      word_cnt_r  <= 5'h0;
      all_space_r <= 1'b1;
      char_bad    <= 1'b0;
    end else begin
      if (st_r == tpl_pkg::TPL_STORE) begin
        if (char_cnt_r < 7'(`TPL_LINE_CHARS)) begin
          char_cnt_r <= char_cnt_r + 7'h1;
        end
        if (tpl_char_of(word_r, unpack_r) != `TPL_SPACE_CODE) begin
          all_space_r <= 1'b0;
        end
        if (!tpl_printable(tpl_char_of(word_r, unpack_r))) begin
          char_bad <= 1'b1;
        end
        if (unpack_r == 3'(`TPL_CHARS_WORD - 1)) begin
          unpack_r <= 3'h0;
          if (word_cnt_r != 5'(LINE_WORDS)) begin
            word_cnt_r <= word_cnt_r + 5'h1;
          end
        end else begin
          unpack_r <= unpack_r + 3'h1;
        end
      // a full line keeps its count through end of record until printed
      end else if ((intr_rise && char_cnt_r != 7'(`TPL_LINE_CHARS)) ||
                   st_r == tpl_pkg::TPL_IDLE) begin
        unpack_r    <= 3'h0;
        char_cnt_r  <= 7'h0;
        word_cnt_r  <= 5'h0;
        all_space_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (st_r == tpl_pkg::TPL_STORE &&
        char_cnt_r < 7'(`TPL_LINE_CHARS)) begin
      line_mem[char_cnt_r] <= tpl_char_of(word_r, unpack_r);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_char <= 6'h00;
    end else if (rd_addr < 7'(`TPL_LINE_CHARS)) begin
      rd_char <= line_mem[rd_addr];
    end else begin
      rd_char <= 6'h00;
    end
  end

  // print and paper pulses
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      print_start <= 1'b0;
      paper_line  <= 1'b0;
      paper_tof   <= 1'b0;
      stopped     <= 1'b0;
    end else begin
      print_start <= (st_r == tpl_pkg::TPL_PACE) && (pace_r == 13'h0) &&
                     !req_s && (char_cnt_r == 7'(`TPL_LINE_CHARS));
      paper_line  <= intr_rise && !mark_s;
      paper_tof   <= intr_rise && mark_s;
      if (st_r == tpl_pkg::TPL_STOP) begin
        stopped <= 1'b1;
      end else if (!offline) begin
        stopped <= 1'b0;
      end
    end
  end
endmodule : tpl_ctrl

// >>> tpl_ctrl_props.sv
/* Checker for the printer-side link controller ports.
   Bound from the testbench top; one clock domain. */
`timescale 1ns/1ps
module tpl_ctrl_props (
  input wire logic       mclk,       // clock
  input wire logic       rst_n,      // reset
  input wire logic       offline,    // off-line switch
  input wire logic       tape_ready, // tape ready
  input wire logic       tape_req,   // tape request pin
  input wire logic       tape_intr,  // tape interrupt pin
  input wire logic       tape_mark,  // interrupt kind
  input wire logic [6:0] rd_addr,    // memory address
  input wire logic       out_req,    // word demand
  input wire logic       paper_line, // line pulse
  input wire logic       paper_tof,  // top of form pulse
  input wire logic       stopped,    // stopped level
  input wire logic       char_bad,   // bad code flag
  input wire logic [5:0] rd_char     // memory data
);
  localparam int PACE = 6749;
  logic [12:0] low_cnt_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // a word capture restarts the pace count; a new off-line run starts full
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) low_cnt_r <= 13'h1FFF;
    else if ($fell(out_req) && offline) low_cnt_r <= 13'h0000;
    else if (!offline) low_cnt_r <= 13'h1FFF;
    else if (low_cnt_r != 13'h1FFF) low_cnt_r <= low_cnt_r + 13'h0001;
  end
  a_req_gated: assert property (
    $rose(out_req) |-> $past(offline) && $past(tape_ready))
    else $error("demand rose while not enabled");
  a_drop_after_ack: assert property (
    $fell(out_req) && offline ##1 !stopped |-> $past(tape_req, 3))
    else $error("demand fell without tape request");
  a_word_pace: assert property (
    $rose(out_req) |-> low_cnt_r >= PACE)
    else $error("demand rose before word pace");
  a_intr_event: assert property (
    $rose(tape_intr) |-> ##[3:7] (paper_line || paper_tof))
    else $error("no paper pulse after interrupt");
  a_line_cause: assert property (
    paper_line |-> $past(tape_intr, 3) && !$past(tape_mark, 3) ##1 !paper_line)
    else $error("line pulse without end of record");
  a_tof_cause: assert property (
    paper_tof |-> $past(tape_intr, 3) && $past(tape_mark, 3) ##1 !paper_tof)
    else $error("top of form without tape mark");
  a_stop_no_req: assert property (
    stopped && $past(stopped) |-> !out_req)
    else $error("demand while stopped");
  a_mem_bound: assert property (
    rd_addr >= 7'h78 |=> rd_char == 6'h00)
    else $error("data beyond line end");
  a_bad_sticky: assert property (
    char_bad |=> char_bad)
    else $error("bad code flag cleared");
  c_word: cover property ($fell(out_req) && offline);
  c_line: cover property (paper_line);
  c_tof: cover property (paper_tof);
endmodule : tpl_ctrl_props

// >>> tpl_tape_model.sv
/* Behavioural tape unit feeding the printer link.
   Words are queued by the testbench; moves after each edge. */
`timescale 1ns/1ps
module tpl_tape_model (
  input  wire logic   mclk,    // clock
  input  wire logic   demand,  // printer word demand
  input  wire logic   mode_ok, // printer mode, at load point
  output logic        ready,   // ready level
  output logic        req,     // input data request
  output logic        intr,    // interrupt
  output logic        mark,    // interrupt kind
  output logic [29:0] data     // data lines
);
  logic [29:0] q[$];
  logic        act;
  int          gap;
  assign ready = mode_ok;
  initial begin
    {req, intr, mark, act} = 4'h0;
    data = 30'h2AAAAAAA;
    gap = 0;
    forever begin
      @(posedge mclk);
      if (demand && ready && q.size() != 0) begin
        act = 1'b1;
        repeat (gap) @(posedge mclk);
        #1 data = q.pop_front();
        @(posedge mclk);
        #1 req = 1'b1;
        while (demand) @(posedge mclk);
        #1 req = 1'b0;
        data = ~data; // released lines do not keep the word
        act = 1'b0;
      end
    end
  end
  task automatic event_send(input logic m);
    @(posedge mclk);
    #1 mark = m;
    intr = 1'b1;
    repeat (8) @(posedge mclk);
    #1 intr = 1'b0;
  endtask : event_send
endmodule : tpl_tape_model

// >>> tape_to_printer_offline_link_tb_top.sv
/* Top testbench for tpl_ctrl against the tape model.
   Full 24-word lines exceed the run budget; short records only. */
`timescale 1ns/1ps
`include "tpl_map.svh"
module tape_to_printer_offline_link_tb_top;
  logic mclk, rst_n, offline, mode_ok, print_done;
  logic [6:0] rd_addr;
  logic tape_ready, tape_req, tape_intr, tape_mark, out_req;
  logic [29:0] tape_data, w0, w1;
  logic print_start, paper_line, paper_tof, stopped, busy, char_bad;
  logic [5:0] rd_char;
  logic [31:0] lfsr_r;
  int num_errors, num_checks;
  tpl_pkg::tpl_paper_t exp_q[$];
  tpl_ctrl dut_u (.mclk(mclk), .rst_n(rst_n), .offline(offline),
    .tape_ready(tape_ready), .tape_req(tape_req), .tape_intr(tape_intr),
    .tape_mark(tape_mark), .tape_data(tape_data), .print_done(print_done),
    .rd_addr(rd_addr), .out_req(out_req), .print_start(print_start),
    .paper_line(paper_line), .paper_tof(paper_tof), .stopped(stopped),
    .busy(busy), .rd_char(rd_char), .char_bad(char_bad));
  tpl_tape_model tape_u (.mclk(mclk), .demand(out_req), .mode_ok(mode_ok),
    .ready(tape_ready), .req(tape_req), .intr(tape_intr), .mark(tape_mark),
    .data(tape_data));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic chk_bit(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_char(input logic [6:0] a, input logic [5:0] e);
    @(posedge mclk);
    #1 rd_addr = a;
    @(posedge mclk);
    #1 num_checks++;
    if (rd_char !== e) begin
      num_errors++;
      $display("Error rd_char expected %h seen %h", e, rd_char);
    end
  endtask : chk_char
  task automatic chk_paper(input tpl_pkg::tpl_paper_t e,
                           input tpl_pkg::tpl_paper_t g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error paper expected %s seen %s", e.name(), g.name());
    end
  endtask : chk_paper
  task automatic new_word(output logic [29:0] w);
    for (int i = 0; i < 5; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      w = {w[23:0], lfsr_r[5] ? `TPL_DIGIT_LO + 6'(lfsr_r[9:6] % 10) :
                               `TPL_LETTER_LO + 6'(lfsr_r[10:6] % 26)};
    end
  endtask : new_word
  task automatic wait_idle;
    int n;
    n = 0;
    while ((tape_u.q.size() != 0 || tape_u.act) && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    chk_bit("tape_idle", 1'b1, n < 20000);
  endtask : wait_idle
  task automatic record_end(input logic m);
    exp_q.push_back(m ? tpl_pkg::TPL_PAPER_TOF : tpl_pkg::TPL_PAPER_LINE);
    tape_u.event_send(m);
    repeat (10) @(posedge mclk);
  endtask : record_end
  task automatic complete_run;
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  always @(posedge mclk) begin
    if (rst_n && (paper_line || paper_tof)) begin
      if (exp_q.size() == 0) chk_paper(tpl_pkg::TPL_PAPER_NONE,
        paper_tof ? tpl_pkg::TPL_PAPER_TOF : tpl_pkg::TPL_PAPER_LINE);
      else chk_paper(exp_q.pop_front(),
        paper_tof ? tpl_pkg::TPL_PAPER_TOF : tpl_pkg::TPL_PAPER_LINE);
    end
  end
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    complete_run();
  end
  initial begin
    {rst_n, offline, mode_ok, print_done} = 4'h0;
    rd_addr = 7'h00;
    lfsr_r = 32'hBBB8;
    repeat (20) @(posedge mclk);
    #1 rst_n = 1'b1;
    offline = 1'b1;
    repeat (10) @(posedge mclk);
    chk_bit("out_req", 1'b0, out_req);
    #1 mode_ok = 1'b1;
    repeat (7) @(posedge mclk);
    chk_bit("out_req", 1'b1, out_req);
    chk_bit("busy", 1'b1, busy);
    tape_u.q.push_back({5{`TPL_SPACE_CODE}});
    wait_idle();
    record_end(1'b0);
    chk_bit("stopped", 1'b1, stopped);
    chk_bit("busy", 1'b0, busy);
    repeat (7000) @(posedge mclk);
    chk_bit("out_req", 1'b0, out_req);
    chk_bit("print_start", 1'b0, print_start);
    #1 offline = 1'b0;
    repeat (3) @(posedge mclk);
    chk_bit("stopped", 1'b0, stopped);
    new_word(w0);
    new_word(w1);
    tape_u.gap = 50;
    tape_u.q.push_back(w0);
    tape_u.q.push_back(w1);
    #1 offline = 1'b1;
    wait_idle();
    for (int a = 0; a < 10; a++)
      chk_char(7'(a), a < 5 ? w0[29-6*a -: 6] : w1[59-6*a -: 6]);
    chk_char(7'h78, 6'h00);
    chk_bit("char_bad", 1'b0, char_bad);
    record_end(1'b0);
    chk_bit("stopped", 1'b1, stopped);
    #1 offline = 1'b0;
    tape_u.gap = 0;
    tape_u.q.push_back({w0[29:6], 6'h00});
    repeat (3) @(posedge mclk);
    #1 offline = 1'b1;
    wait_idle();
    repeat (10) @(posedge mclk);
    chk_bit("char_bad", 1'b1, char_bad);
    record_end(1'b1);
    chk_bit("stopped", 1'b1, stopped);
    chk_bit("out_req", 1'b0, out_req);
    chk_bit("paper_left", 1'b1, exp_q.size() == 0);
    complete_run();
  end
endmodule : tape_to_printer_offline_link_tb_top
bind tpl_ctrl tpl_ctrl_props chk_u (.mclk(mclk), .rst_n(rst_n),
  .offline(offline), .tape_ready(tape_ready), .tape_req(tape_req),
  .tape_intr(tape_intr), .tape_mark(tape_mark), .rd_addr(rd_addr),
  .out_req(out_req), .paper_line(paper_line), .paper_tof(paper_tof),
  .stopped(stopped), .char_bad(char_bad), .rd_char(rd_char));
